// [inc/tws_pkg.sv]
/*
  Constants for the waveform timer: register offsets, field positions,
  reset values, waveform modes and command codes.
  Assumes a 32-bit Wishbone slave with byte addresses, one register a word.
*/
package tws_pkg;
  localparam int          CNT_W         = 16;
  localparam int          NCH           = 3;
  localparam int          ADR_W         = 8;
  localparam int          DIV_W         = 10;

  localparam logic [7:0]  ADR_CTRL_A    = 8'h00;
  localparam logic [7:0]  ADR_CTRL_B    = 8'h04;
  localparam logic [7:0]  ADR_CTRL_D    = 8'h08;
  localparam logic [7:0]  ADR_CTRL_E_CLR = 8'h0c;
  localparam logic [7:0]  ADR_CTRL_E_SET = 8'h10;
  localparam logic [7:0]  ADR_CTRL_F_CLR = 8'h14;
  localparam logic [7:0]  ADR_CTRL_F_SET = 8'h18;
  localparam logic [7:0]  ADR_FLAGS     = 8'h1c;
  localparam logic [7:0]  ADR_COUNTER   = 8'h20;
  localparam logic [7:0]  ADR_PERIOD    = 8'h24;
  localparam logic [7:0]  ADR_COMPARE0  = 8'h28;
  localparam logic [7:0]  ADR_PERIOD_SH = 8'h34;
  localparam logic [7:0]  ADR_COMP_SH0  = 8'h38;

  localparam int          CA_EN_BIT     = 0;
  localparam int          CA_PSC_LSB    = 1;
  localparam int          CB_WG_LSB     = 0;
  localparam int          CB_OE_LSB     = 4;
  localparam int          CE_DIR_BIT    = 0;
  localparam int          CE_LOCK_UPDATE_BIT   = 1;
  localparam int          CE_CMD_LSB    = 2;
  localparam int          FLG_OVF_BIT   = 0;
  localparam int          FLG_HUNF_BIT  = 1;
  localparam int          FLG_CMP_LSB   = 4;

  localparam logic [15:0] RST_PERIOD    = 16'hffff;
  localparam logic [15:0] RST_ZERO      = 16'h0000;

  localparam logic [2:0]  WG_NORMAL     = 3'h0;
  localparam logic [2:0]  WG_FRQ        = 3'h1;
  localparam logic [2:0]  WG_ONE_SLOPE  = 3'h3;
  localparam logic [2:0]  WG_DS_TOP     = 3'h5;
  localparam logic [2:0]  WG_DS_BOTH    = 3'h6;
  localparam logic [2:0]  WG_DS_FLOOR   = 3'h7;

  typedef enum logic [1:0] {
    TWS_CMD_NONE    = 2'h0,
    TWS_CMD_UPDATE  = 2'h1,
    TWS_CMD_RESTART = 2'h2,
    TWS_CMD_RESET   = 2'h3
  } tws_cmd_t;
endpackage : tws_pkg

// [hdl/tws_timer.sv]
/*
  Waveform timer: 16-bit counter with three compare channels, frequency,
  one-slope and dual-slope PWM, pin override, commands and dual byte mode.
  Assumes a classic Wishbone master and one clock for bus and timer.
*/
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module tws_timer
  import tws_pkg::*;
#(
  parameter int WIDTH    = CNT_W,
  parameter int CHANNELS = NCH
) (
  input  wire logic             clk_i,          // 50 MHz clock
  input  wire logic             rst_i,          // synchronous reset
  input  wire logic             cyc_i,          // Wishbone cycle
  input  wire logic             stb_i,          // Wishbone strobe
  input  wire logic             we_i,           // Wishbone write
  input  wire logic [ADR_W-1:0] adr_i,          // Wishbone byte address
  input  wire logic [3:0]       sel_i,          // Wishbone byte lanes
  input  wire logic [31:0]      dat_i,          // Wishbone write data
  output logic      [31:0]      dat_o,          // Wishbone read data
  output logic                  ack_o,          // Wishbone acknowledge
  output logic      [5:0]       waveform_o,     // waveforms, high half split
  output logic      [5:0]       pin_override_o, // pin takes the waveform
  output logic                  ovf_o,          // overflow or low underflow
  output logic                  hunf_o,         // high byte underflow
  output logic      [2:0]       cmp_o           // compare match pulses
);
  if (WIDTH != CNT_W || CHANNELS != NCH) begin : g_bad_param
    $error("tws_timer supports only 16 bits and three channels");
  end

  logic        en;
  logic [2:0]  psc_sel;
  logic [2:0]  wg;
  logic [2:0]  oe;
  logic        split;
  logic        dir;
  logic        lock_update;
  logic [3:0]  bv;
  logic [7:0]  flags;
  logic [15:0] cnt;
  logic [15:0] per;
  logic [15:0] per_sh;
  logic [15:0] cmp    [3];
  logic [15:0] cmp_sh [3];
  logic [2:0]  wave_lo;
  logic [2:0]  wave_hi;
  logic [DIV_W-1:0] div;

  // Bus decode: writes take effect at the edge where ack is high.
  logic     wr;
  logic     hard_rst;
  tws_cmd_t cmd;
  assign wr  = cyc_i && stb_i && we_i && ack_o;
  assign cmd = tws_cmd_t'(dat_i[CE_CMD_LSB +: 2]);
  logic cmd_wr;
  assign cmd_wr   = wr && adr_i == ADR_CTRL_E_SET && sel_i[0];
  assign hard_rst = cmd_wr && cmd == TWS_CMD_RESET && !en;
  logic restart;
  logic upd_cmd;
  assign restart = cmd_wr && cmd == TWS_CMD_RESTART;
  assign upd_cmd = cmd_wr && cmd == TWS_CMD_UPDATE;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  function automatic logic [DIV_W-1:0] psc_mask(input logic [2:0] s);
    case (s)
      3'h0:    psc_mask = 10'h000;
      3'h1:    psc_mask = 10'h001;
      3'h2:    psc_mask = 10'h003;
      3'h3:    psc_mask = 10'h007;
      3'h4:    psc_mask = 10'h00f;
      3'h5:    psc_mask = 10'h03f;
      3'h6:    psc_mask = 10'h0ff;
      default: psc_mask = 10'h3ff;
    endcase
  endfunction : psc_mask

  // Prescaler: tick when the low bits of the free divider are all ones.
  logic tick;
  assign tick = en && &(div | ~psc_mask(psc_sel));
  always_ff @(posedge clk_i) begin
    if (rst_i || hard_rst || !en) begin
      div <= '0;
    end else begin
      div <= div + 10'h001;
    end
  end

  // Next counter value and slope events.
  logic        ds;
  logic [15:0] top;
  logic [15:0] next_cnt;
  logic        next_dir;
  logic        floor_evt;
  logic        hunf_evt;
  logic [2:0]  hit;
  logic [2:0]  next_lo;
  logic [2:0]  next_hi;
  logic [7:0]  nl;
  logic [7:0]  nh;
  assign ds  = wg == WG_DS_TOP || wg == WG_DS_BOTH || wg == WG_DS_FLOOR;
  assign top = (wg == WG_FRQ) ? cmp[0] : per;

  always_comb begin
    next_cnt  = cnt;
    next_dir  = dir;
    floor_evt = 1'b0;
    hunf_evt  = 1'b0;
    nl        = (cnt[7:0] == 8'h00) ? per[7:0] : cnt[7:0] - 8'h01;
    nh        = (cnt[15:8] == 8'h00) ? per[15:8] : cnt[15:8] - 8'h01;
    if (split) begin
      next_cnt  = {nh, nl};
      floor_evt = cnt[7:0] == 8'h00;
      hunf_evt  = cnt[15:8] == 8'h00;
    end else if (ds) begin
      if (!dir && cnt < per) begin
        next_cnt = cnt + 16'h0001;
        next_dir = next_cnt >= per;
      end else if (cnt != 16'h0000) begin
        next_cnt = cnt - 16'h0001;
        next_dir = next_cnt != 16'h0000;
        floor_evt = next_cnt == 16'h0000;
      end else begin
        next_cnt = cnt + 16'h0001;
        next_dir = 1'b0;
      end
    end else if (!dir) begin
      next_cnt  = (cnt >= top) ? 16'h0000 : cnt + 16'h0001;
      floor_evt = cnt >= top;
    end else begin
      next_cnt  = (cnt == 16'h0000) ? top : cnt - 16'h0001;
      floor_evt = cnt == 16'h0000;
    end
  end

  always_comb begin
    next_lo = wave_lo;
    next_hi = wave_hi;
    for (int k = 0; k < NCH; k++) begin
      hit[k] = split ? cnt[7:0] == cmp[k][7:0] : cnt == cmp[k];
      if (split) begin
        next_lo[k] = nl < cmp[k][7:0];
        next_hi[k] = nh < cmp[k][15:8];
      end else if (wg == WG_FRQ) begin
        next_lo[k] = hit[k] ? !wave_lo[k] : wave_lo[k];
      end else if (wg == WG_ONE_SLOPE) begin
        if (next_cnt == cmp[k]) begin
          next_lo[k] = 1'b0;
        end else if (next_cnt == 16'h0000) begin
          next_lo[k] = 1'b1;
        end
      end else if (ds) begin
        if (next_cnt == cmp[k]) begin
          next_lo[k] = (cmp[k] == per) ? 1'b1 : next_dir;
        end else if (next_cnt == 16'h0000) begin
          next_lo[k] = cmp[k] != 16'h0000;
        end
      end else begin
        next_lo[k] = 1'b0;
      end
    end
  end

  // Update condition: copy valid shadows at floor unless locked, or on the update command; not in dual byte mode.
  logic upd;
  assign upd = !split &&
               (upd_cmd || (tick && floor_evt && !lock_update));

  always_ff @(posedge clk_i) begin
    if (rst_i || hard_rst) begin
      cnt <= RST_ZERO;
      dir <= 1'b0;
    end else if (wr && adr_i == ADR_COUNTER) begin
      cnt <= merge(cnt, dat_i, sel_i);
    end else if (restart) begin
      cnt <= RST_ZERO;
      dir <= 1'b0;
    end else begin
      if (tick) begin
        cnt <= next_cnt;
        dir <= split ? 1'b1 : next_dir;
      end
      if (wr && sel_i[0] && adr_i == ADR_CTRL_E_CLR &&
          dat_i[CE_DIR_BIT]) begin
        dir <= 1'b0;
      end else if (cmd_wr && dat_i[CE_DIR_BIT]) begin
        dir <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hard_rst || restart) begin
      wave_lo <= 3'h0;
      wave_hi <= 3'h0;
    end else if (tick) begin
      wave_lo <= next_lo;
      wave_hi <= split ? next_hi : 3'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hard_rst) begin
      en      <= 1'b0;
      psc_sel <= 3'h0;
      wg      <= WG_NORMAL;
      oe      <= 3'h0;
      split   <= 1'b0;
      lock_update    <= 1'b0;
    end else if (wr && sel_i[0]) begin
      case (adr_i)
        ADR_CTRL_A: begin
          en      <= dat_i[CA_EN_BIT];
          psc_sel <= dat_i[CA_PSC_LSB +: 3];
        end
        ADR_CTRL_B: begin
          wg <= dat_i[CB_WG_LSB +: 3];
          oe <= dat_i[CB_OE_LSB +: 3];
        end
        ADR_CTRL_D:     split <= dat_i[0];
        ADR_CTRL_E_CLR: lock_update  <= lock_update && !dat_i[CE_LOCK_UPDATE_BIT];
        ADR_CTRL_E_SET: lock_update  <= lock_update || dat_i[CE_LOCK_UPDATE_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hard_rst) begin
      per    <= RST_PERIOD;
      per_sh <= RST_PERIOD;
      bv     <= 4'h0;
      for (int k = 0; k < NCH; k++) begin
        cmp[k]    <= RST_ZERO;
        cmp_sh[k] <= RST_ZERO;
      end
    end else begin
      if (upd) begin
        if (bv[0]) per <= per_sh;
        for (int k = 0; k < NCH; k++) begin
          if (bv[k+1]) cmp[k] <= cmp_sh[k];
        end
        bv <= 4'h0;
      end
      if (wr) begin
        if (adr_i == ADR_PERIOD) per <= merge(per, dat_i, sel_i);
        if (adr_i == ADR_PERIOD_SH) begin
          per_sh <= merge(per_sh, dat_i, sel_i);
          bv[0]  <= 1'b1;
        end
        for (int k = 0; k < NCH; k++) begin
          if (adr_i == ADR_COMPARE0 + 8'(4 * k)) begin
            cmp[k] <= merge(cmp[k], dat_i, sel_i);
          end
          if (adr_i == ADR_COMP_SH0 + 8'(4 * k)) begin
            cmp_sh[k] <= merge(cmp_sh[k], dat_i, sel_i);
            bv[k+1]   <= 1'b1;
          end
        end
        if (adr_i == ADR_CTRL_F_CLR && sel_i[0]) bv <= bv & ~dat_i[3:0];
        if (adr_i == ADR_CTRL_F_SET && sel_i[0]) bv <= bv | dat_i[3:0];
      end
    end
  end

  // Flags: write one to clear; a new event in the same cycle wins.
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  always_comb begin
    flag_set = 8'h00;
    flag_set[FLG_OVF_BIT]  = tick && floor_evt;
    flag_set[FLG_HUNF_BIT] = tick && split && hunf_evt;
    flag_set[FLG_CMP_LSB +: 3] = hit & {3{tick && wg != WG_NORMAL}};
    flag_clr = (wr && sel_i[0] && adr_i == ADR_FLAGS) ? dat_i[7:0] : 8'h00;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hard_rst) begin
      flags  <= 8'h00;
      ovf_o  <= 1'b0;
      hunf_o <= 1'b0;
      cmp_o  <= 3'h0;
    end else begin
      flags  <= (flags & ~flag_clr) | flag_set;
      ovf_o  <= flag_set[FLG_OVF_BIT];
      hunf_o <= flag_set[FLG_HUNF_BIT];
      cmp_o  <= flag_set[FLG_CMP_LSB +: 3];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waveform_o     <= 6'h00;
      pin_override_o <= 6'h00;
    end else begin
      waveform_o          <= {split ? wave_hi : 3'h0, wave_lo};
      pin_override_o[2:0] <= (wg != WG_NORMAL) ? oe : 3'h0;
      pin_override_o[5:3] <= (wg != WG_NORMAL && split) ? oe : 3'h0;
    end
  end

  // Read mux and acknowledge, one cycle after the request.
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    case (adr_i)
      ADR_CTRL_A:     rd[3:0] = {psc_sel, en};
      ADR_CTRL_B:     rd[6:0] = {oe, 1'b0, wg};
      ADR_CTRL_D:     rd[0]   = split;
      ADR_CTRL_E_CLR,
      ADR_CTRL_E_SET: rd[1:0] = {lock_update, dir};
      ADR_CTRL_F_CLR,
      ADR_CTRL_F_SET: rd[3:0] = bv;
      ADR_FLAGS:      rd[7:0] = flags;
      ADR_COUNTER:    rd[15:0] = cnt;
      ADR_PERIOD:     rd[15:0] = per;
      ADR_PERIOD_SH:  rd[15:0] = per_sh;
      default: begin
        for (int k = 0; k < NCH; k++) begin
          if (adr_i == ADR_COMPARE0 + 8'(4 * k)) rd[15:0] = cmp[k];
          if (adr_i == ADR_COMP_SH0 + 8'(4 * k)) rd[15:0] = cmp_sh[k];
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
      if (cyc_i && stb_i && !ack_o) dat_o <= rd;
    end
  end
endmodule : tws_timer
`default_nettype wire

// [dv/tws_timer_sva.sv]
/*
  Checker for the waveform timer: bus handshake, pin override and the
  split-mode outputs. Sees only the ports of tws_timer; bound below.
*/
`timescale 1ns/100ps
`default_nettype none
module tws_timer_sva
  import tws_pkg::*;
(
  input wire logic             clk_i,          // clock
  input wire logic             rst_i,          // synchronous reset
  input wire logic             cyc_i,          // bus cycle
  input wire logic             stb_i,          // bus strobe
  input wire logic             we_i,           // bus write
  input wire logic [ADR_W-1:0] adr_i,          // bus address
  input wire logic [3:0]       sel_i,          // byte lanes
  input wire logic [31:0]      dat_i,          // write data
  input wire logic             ack_o,          // acknowledge
  input wire logic [5:0]       waveform_o,     // waveforms
  input wire logic [5:0]       pin_override_o, // pin override
  input wire logic             ovf_o,          // overflow pulse
  input wire logic             hunf_o,         // high underflow pulse
  input wire logic [2:0]       cmp_o           // compare pulses
);
  logic [2:0] oe_q;
  logic       mode_q;
  logic       split_q;
  logic       en_q;
  logic       wr;
  assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  // Mirror of the control bits that decide the pin override.
  always_ff @(posedge clk_i) begin
    if (rst_i || (wr && adr_i == ADR_CTRL_E_SET && !en_q &&
        dat_i[CE_CMD_LSB +: 2] == TWS_CMD_RESET)) begin
      oe_q    <= 3'h0;
      mode_q  <= 1'b0;
      split_q <= 1'b0;
      en_q    <= 1'b0;
    end else if (wr) begin
      if (adr_i == ADR_CTRL_A) en_q <= dat_i[CA_EN_BIT];
      if (adr_i == ADR_CTRL_D) split_q <= dat_i[0];
      if (adr_i == ADR_CTRL_B) begin
        oe_q   <= dat_i[CB_OE_LSB +: 3];
        mode_q <= dat_i[2:0] != 3'h0;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_done;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_next: assert property (s_req |=> s_done)
    else $error("ack missing or too long");
  a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  a_oe_low: assert property (
    pin_override_o[2:0] == $past(oe_q & {3{mode_q}}))
    else $error("low pin override wrong");
  a_oe_high: assert property (
    pin_override_o[5:3] == $past(oe_q & {3{mode_q && split_q}}))
    else $error("high pin override wrong");
  a_hunf_split: assert property (hunf_o |-> $past(split_q))
    else $error("high underflow outside split");
  a_high_wave_off: assert property (!split_q && !$past(split_q) &&
    !$past(split_q, 2) |-> waveform_o[5:3] == 3'h0)
    else $error("high waveforms outside split");
  a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !ack_o && waveform_o == 6'h00 && pin_override_o == 6'h00 &&
    !ovf_o && !hunf_o && cmp_o == 3'h0)
    else $error("outputs active after reset");
  a_reset_cmd: assert property (
    wr && adr_i == ADR_CTRL_E_SET && !en_q &&
    dat_i[CE_CMD_LSB +: 2] == TWS_CMD_RESET |-> ##2 pin_override_o == 6'h00)
    else $error("reset command left override");
endmodule : tws_timer_sva
bind tws_timer tws_timer_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .ack_o(ack_o), .waveform_o(waveform_o),
  .pin_override_o(pin_override_o), .ovf_o(ovf_o), .hunf_o(hunf_o),
  .cmp_o(cmp_o));
`default_nettype wire

// [dv/tws_pin_model.sv]
/*
  Port pin output logic: a pin shows the port value unless the timer
  overrides it, then optionally inverted. Port value and inversion come from the bench, the rest from the timer.
*/
`timescale 1ns/100ps
`default_nettype none
module tws_pin_model (
  input  wire logic [5:0] wave_i,     // timer waveforms
  input  wire logic [5:0] override_i, // timer takes the pin
  input  wire logic [5:0] port_out_i, // plain port value
  input  wire logic [5:0] invert_i,   // pin inversion
  output logic      [5:0] pin_o       // pin levels
);
  assign pin_o = (override_i & wave_i | ~override_i & port_out_i) ^
                 invert_i;
endmodule : tws_pin_model
`default_nettype wire

// [dv/tws_timer_tb_top.sv]
/*
  Bench for the waveform timer: register traffic, waveform timing in every
  mode but normal, commands and split mode. Assumes a one-cycle bus answer.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %0t: got %0h expected %0h", $time, (a), (e)); end end
module tws_timer_tb_top
  import tws_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [5:0]  pout  = 6'h00;
  logic [5:0]  inv   = 6'h00;
  logic [31:0] rdat;
  logic [31:0] ev;
  logic [31:0] v;
  logic        ack;
  logic        ovf;
  logic        hunf;
  logic [2:0]  cmp;
  logic [5:0]  wave;
  logic [5:0]  ovr;
  logic [5:0]  pin;
  logic [10:0] obs;
  logic [31:0] expq[$];
  logic [2:0]  dsm[3] = '{WG_DS_TOP, WG_DS_BOTH, WG_DS_FLOOR};
  int          errors = 0;
  int          total_checks = 0;
  int          hi;
  int          lo;
  always #10 clk_i = ~clk_i;
  assign obs = {cmp, hunf, ovf, wave};
  tws_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat),
    .ack_o(ack), .waveform_o(wave), .pin_override_o(ovr), .ovf_o(ovf),
    .hunf_o(hunf), .cmp_o(cmp));
  tws_pin_model u_pin (.wave_i(wave), .override_i(ovr), .port_out_i(pout),
    .invert_i(inv), .pin_o(pin));
  task automatic end_sim();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, s, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      end_sim();
    end
    {cyc, stb, we} <= 3'b000;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, 4'h3, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 4'hf, 32'h0);
  endtask : rd
  // Syncs to a rising edge, then counts the high and the low cycles.
  task automatic meas(input int i, output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    while (obs[i] !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    while (obs[i] !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    while (obs[i] === 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
      h++;
    end
    while (obs[i] === 1'b0 && n < 3000) begin
      @(posedge clk_i);
      n++;
      l++;
    end
    if (n >= 3000) begin
      errors++;
      end_sim();
    end
  endtask : meas
  task automatic steady(input int i, input logic b);
    logic bad;
    bad = 1'b0;
    repeat (24) begin
      @(posedge clk_i);
      if (obs[i] !== b) bad = 1'b1;
    end
    `CHK(bad, 1'b0)
  endtask : steady
  task automatic cfg(input logic [2:0] m, input logic [2:0] p,
                     input logic [15:0] per, c0, c1, c2);
    wr(ADR_CTRL_A, 32'h0);
    wr(ADR_CTRL_E_CLR, 32'h1);
    wr(ADR_COUNTER, 32'h0);
    wr(ADR_PERIOD, {16'h0, per});
    wr(ADR_COMPARE0, {16'h0, c0});
    wr(ADR_COMPARE0 + 8'h04, {16'h0, c1});
    wr(ADR_COMPARE0 + 8'h08, {16'h0, c2});
    wr(ADR_CTRL_B, {25'h0, 3'h7, 1'b0, m});
    wr(ADR_CTRL_A, {28'h0, p, 1'b1});
  endtask : cfg
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      ev = expq.pop_front();
      `CHK(rdat, ev)
    end
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    end_sim();
  end
  initial begin
    void'($urandom(23210));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_PERIOD, {16'h0, RST_PERIOD});
    v = $urandom;
    pout <= v[5:0];
    inv <= v[11:6];
    wr(ADR_COMPARE0, v);
    bus(1'b1, ADR_COMPARE0, 4'h2, ~v);
    rd(ADR_COMPARE0, {16'h0, ~v[15:8], v[7:0]});
    wr(8'h80, v);
    rd(8'h80, 32'h0);
    for (int p = 0; p < 4; p++) begin
      cfg(WG_FRQ, 3'(p), 16'h00ff, 16'h0, 16'h0, 16'h0);
      meas(0, hi, lo);
      `CHK(hi, 1 << p)
      `CHK(lo, 1 << p)
    end
    cfg(WG_FRQ, 3'h0, 16'h00ff, 16'h3, 16'h0, 16'h0);
    meas(0, hi, lo);
    `CHK(hi + lo, 8)
    @(negedge clk_i);
    `CHK(pin, {pout[5:3], wave[2:0]} ^ inv)
    cfg(WG_ONE_SLOPE, 3'h1, 16'h4, 16'h2, 16'h0, 16'h5);
    meas(0, hi, lo);
    `CHK(hi, 4)
    `CHK(hi + lo, 10)
    steady(1, 1'b0);
    steady(2, 1'b1);
    meas(8, hi, lo);
    `CHK(hi, 1)
    `CHK(hi + lo, 10)
    wr(ADR_CTRL_E_SET, 32'h2);
    wr(ADR_COMP_SH0, 32'h1);
    repeat (30) @(posedge clk_i);
    rd(ADR_COMPARE0, 32'h2);
    wr(ADR_CTRL_E_SET, {28'h0, TWS_CMD_UPDATE, 2'h0});
    rd(ADR_COMPARE0, 32'h1);
    wr(ADR_CTRL_E_CLR, 32'h2);
    wr(ADR_COMP_SH0, 32'h3);
    repeat (30) @(posedge clk_i);
    rd(ADR_COMPARE0, 32'h3);
    foreach (dsm[k]) begin
      cfg(dsm[k], 3'h0, 16'h4, 16'h1, 16'h0, 16'h4);
      meas(0, hi, lo);
      `CHK(hi, 2)
      `CHK(hi + lo, 8)
      steady(1, 1'b0);
      steady(2, 1'b1);
    end
    wr(ADR_CTRL_A, 32'h0);
    wr(ADR_CTRL_E_SET, 32'h1);
    wr(ADR_COUNTER, 32'h5);
    wr(ADR_CTRL_E_SET, {28'h0, TWS_CMD_RESTART, 2'h0});
    rd(ADR_COUNTER, 32'h0);
    rd(ADR_CTRL_E_CLR, 32'h0);
    `CHK(wave, 6'h00)
    wr(ADR_CTRL_A, 32'h1);
    wr(ADR_CTRL_E_SET, {28'h0, TWS_CMD_RESET, 2'h0});
    rd(ADR_PERIOD, 32'h4);
    wr(ADR_CTRL_A, 32'h0);
    wr(ADR_CTRL_E_SET, {28'h0, TWS_CMD_RESET, 2'h0});
    rd(ADR_PERIOD, {16'h0, RST_PERIOD});
    rd(ADR_CTRL_B, 32'h0);
    @(negedge clk_i);
    `CHK(pin, pout ^ inv)
    wr(ADR_CTRL_D, 32'h1);
    bus(1'b1, ADR_PERIOD, 4'h1, 32'h0003);
    bus(1'b1, ADR_PERIOD, 4'h2, 32'h0500);
    wr(ADR_COMPARE0, 32'h0201);
    wr(ADR_CTRL_B, {25'h0, 3'h1, 1'b0, WG_ONE_SLOPE});
    wr(ADR_CTRL_A, 32'h1);
    meas(6, hi, lo);
    `CHK(hi + lo, 4)
    meas(7, hi, lo);
    `CHK(hi + lo, 6)
    meas(0, hi, lo);
    `CHK(hi, 1)
    meas(3, hi, lo);
    `CHK(hi, 2)
    `CHK(hi + lo, 6)
    end_sim();
  end
endmodule : tws_timer_tb_top
`default_nettype wire
